// *** hdl/lsn_pkg.sv ***
// constants, types and register layout of the link start-up negotiation block
package lsn_pkg;
	// register byte offsets
	localparam logic [7:0]  ADDR_CTRL  = 8'h00;
	localparam logic [7:0]  ADDR_NPTX  = 8'h04;
	localparam logic [7:0]  ADDR_MODE  = 8'h08;
	localparam logic [7:0]  ADDR_STAT  = 8'h0C;
	localparam logic [7:0]  ADDR_ADV   = 8'h10;
	// control field positions
	localparam int CTRL_AUTONEG_ENABLE_BIT    = 0;
	localparam int CTRL_PD      = 1;
	localparam int CTRL_RESTART = 2;
	localparam int CTRL_SRST    = 3;
	localparam int CTRL_XOVER   = 4;
	localparam int CTRL_POL     = 5;
	localparam int CTRL_ADS     = 6;
	localparam int CTRL_SPD     = 8;
	localparam int CTRL_FDX     = 10;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0773;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0171;
	// status field positions
	localparam int STAT_LINK = 3;
	localparam int STAT_SPD  = 4;
	localparam int STAT_FDX  = 6;
	localparam int STAT_CNT  = 7;
	localparam int STAT_POL  = 10;
	localparam int STAT_MAP  = 14;
	localparam int STAT_DROP = 16;
	// line speeds
	localparam logic [1:0] SPD_10   = 2'h0;
	localparam logic [1:0] SPD_100  = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	// mac interface modes
	localparam logic [1:0] MODE_RGMII = 2'h0;
	localparam logic [1:0] MODE_SGMII = 2'h1;
	localparam logic [1:0] MODE_RTBI  = 2'h2;
	localparam logic [1:0] MODE_FIBER = 2'h3;
	// counts and answers
	localparam logic [2:0] ATTEMPT_MAX     = 3'h3;
	localparam logic [7:0] XOVER_DWELL_CYC = 8'h40;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;
	// start-up states, gray along idle-xover-link_negotiation-train-link
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_XOVER = 3'h1,
		ST_LINK_NEGOTIATION  = 3'h3,
		ST_TRAIN = 3'h2,
		ST_LINK  = 3'h6
	} lsn_state_t;
endpackage : lsn_pkg

// *** hdl/lsn_top.sv ***
// link start-up control: negotiation, parallel detect, downspeed, crossover, polarity
// Operation
// - every link-up starts with negotiation unless the enable bit is cleared
// - negotiation restarts on power-up, power-down exit, resets, restart bit, link-down
// - crossover detection runs before negotiation unless disabled
// - crossover detection also runs when negotiation is disabled
// - non-negotiating partner: parallel detect its speed, link half duplex
// - parallel detection only for 10 and 100, never gigabit
// - extended pages including gigabit pages are exchanged autonomously
// - advertisement restricted to speeds the mac interface mode carries
// - serial mac mode restarts mac-side negotiation on every copper speed change
// - cabling unfit for gigabit removes gigabit from the advertisement
// - poor received signal integrity also triggers downspeed fallback
// - gigabit attempts counted, fallback once count exceeds three
// - attempt counter cleared after each successful gigabit link-up
// - downspeed fallback disabled in gigabit-only configurations
// - crossover and polarity correction enabled after reset
// - four pair mappings, folded pairwise at 10 and 100
// - crossover detection at 10/100 relies on valid link pulses
// - receive polarity corrected from pulses or during gigabit training
// - polarity frozen while the link is up
// - serializer serves fiber or serial mac mode, never both
// - fiber runs only at gigabit with gigabit-capable mac interfaces
`timescale 1ns/1ps
module lsn_top
	import lsn_pkg::*;
(
	// clock, reset, enable
	input  wire  logic        aclk,
	input  wire  logic        aresetn,
	input  wire  logic        ce,
	// axi4-lite slave
	input  wire  logic [7:0]  s_axi_awaddr,
	input  wire  logic        s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire  logic [31:0] s_axi_wdata,
	input  wire  logic [3:0]  s_axi_wstrb,
	input  wire  logic        s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire  logic        s_axi_bready,
	input  wire  logic [7:0]  s_axi_araddr,
	input  wire  logic        s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire  logic        s_axi_rready,
	// line-side status from the pma
	input  wire  logic        pulse_ok,
	input  wire  logic        pdet_valid,
	input  wire  logic [1:0]  pdet_speed,
	input  wire  logic        link_negotiation_done,
	input  wire  logic [1:0]  link_negotiation_speed,
	input  wire  logic        link_negotiation_fdx,
	input  wire  logic        train_ok,
	input  wire  logic        train_fail,
	input  wire  logic        cable_unfit,
	input  wire  logic        sig_poor,
	input  wire  logic        link_lost,
	input  wire  logic [3:0]  pulse_pol_inv,
	input  wire  logic [3:0]  train_pol_inv,
	// control toward the pma and mac side
	output logic              link_negotiation_start,
	output logic [2:0]        adv_speeds,
	output logic              next_page_bit,
	output logic              link_up,
	output logic [1:0]        link_speed,
	output logic              link_fdx,
	output logic [1:0]        pair_map,
	output logic [3:0]        pol_inv,
	output logic              sgmii_an_start,
	output logic [1:0]        sgmii_speed,
	output logic              serdes_sgmii,
	output logic              serdes_fiber
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// speeds a mac mode carries, as {1000,100,10}
	function automatic logic [2:0] mode_speeds(input logic [1:0] m);
		return (m == MODE_RTBI || m == MODE_FIBER) ? 3'h4 : 3'h7;
	endfunction : mode_speeds

	////////////////////////////////////////////////////////////////////////
	// declarations

	lsn_state_t  state_q;
	logic [31:0] ctrl_q;
	logic        nptx_q;
	logic [1:0]  mode_q;
	logic        srst_q;
	logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q, rresp_q;
	logic        wr_fire, restart_pulse, restart_trig, pd_fall;
	logic [7:0]  dwell_q;
	logic [1:0]  map_q, spd_q, sg_spd_q;
	logic        fdx_q, gig_drop_q, link_negotiation_start_q, sg_start_q;
	logic [2:0]  cnt_q;
	logic [3:0]  pol_q;
	logic        gig_only, ads_allowed, fallback, link_enter;
	logic [1:0]  enter_spd;

	assign gig_only    = (mode_speeds(mode_q) == 3'h4);
	assign ads_allowed = ctrl_q[CTRL_ADS] & ~gig_only;
	assign wr_fire     = aw_hold_q & w_hold_q & ~bvalid_q;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write path

	assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
	assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// address and data captured in either order, answered once both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_NPTX ||
					awaddr_q == ADDR_MODE || awaddr_q == ADDR_STAT ||
					awaddr_q == ADDR_ADV) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// control, next-page and mode registers; restart and soft reset self-clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			nptx_q <= 1'b0;
			mode_q <= MODE_RGMII;
			srst_q <= 1'b0;
		end else if (ce) begin
			srst_q <= 1'b0;
			if (wr_fire && awaddr_q == ADDR_CTRL) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_WMASK;
				srst_q <= wdata_q[CTRL_SRST] & wstrb_q[0];
			end
			if (wr_fire && awaddr_q == ADDR_NPTX && wstrb_q[0]) begin
				nptx_q <= wdata_q[0];
			end
			if (wr_fire && awaddr_q == ADDR_MODE && wstrb_q[0]) begin
				mode_q <= wdata_q[1:0];
			end
		end
	end

	assign restart_pulse = wr_fire & (awaddr_q == ADDR_CTRL) & wstrb_q[0] &
		wdata_q[CTRL_RESTART];
	assign pd_fall      = wr_fire & (awaddr_q == ADDR_CTRL) & wstrb_q[0] &
		ctrl_q[CTRL_PD] & ~wdata_q[CTRL_PD];
	assign restart_trig = restart_pulse | srst_q | pd_fall;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read path

	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// read mux; unmapped offsets read zero with slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rresp_q  <= RESP_OKAY;
				rdata_q  <= 32'h0000_0000;
				case (s_axi_araddr)
					ADDR_CTRL: rdata_q <= ctrl_q | {28'h0000000, srst_q, 3'h0};
					ADDR_NPTX: rdata_q <= {31'h00000000, nptx_q};
					ADDR_MODE: rdata_q <= {30'h00000000, mode_q};
					ADDR_STAT: rdata_q <= {15'h0000, gig_drop_q, map_q, pol_q, cnt_q,
						fdx_q, spd_q, state_q == ST_LINK, state_q};
					ADDR_ADV:  rdata_q <= {29'h00000000, adv_speeds};
					default:   rresp_q <= RESP_SLVERR;
				endcase
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start-up sequencer

	// downspeed: unfit cable, poor signal, or too many gigabit attempts
	assign fallback = ads_allowed & (cable_unfit | sig_poor |
		(train_fail & (cnt_q > ATTEMPT_MAX)));

	// speed at which the link comes up on leaving negotiation
	always_comb begin
		enter_spd = spd_q;
		if (mode_q == MODE_FIBER) begin
			enter_spd = SPD_1000;
		end else if (!ctrl_q[CTRL_AUTONEG_ENABLE_BIT]) begin
			enter_spd = ctrl_q[CTRL_SPD +: 2];
		end else if (link_negotiation_done) begin
			enter_spd = link_negotiation_speed;
		end else if (pdet_valid) begin
			enter_spd = pdet_speed;
		end
	end

	// main state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q      <= ST_IDLE;
			link_negotiation_start_q <= 1'b0;
			spd_q        <= SPD_10;
			fdx_q        <= 1'b0;
		end else if (ce) begin
			link_negotiation_start_q <= 1'b0;
			if (ctrl_q[CTRL_PD]) begin
				state_q <= ST_IDLE;
			end else if (restart_trig) begin
				state_q <= ST_XOVER;
			end else begin
				case (state_q)
					ST_IDLE: begin
						state_q <= ST_XOVER;
					end
					ST_XOVER: begin
						if (!ctrl_q[CTRL_XOVER] || pulse_ok) begin
							state_q      <= ST_LINK_NEGOTIATION;
							link_negotiation_start_q <= ctrl_q[CTRL_AUTONEG_ENABLE_BIT];
						end
					end
					ST_LINK_NEGOTIATION: begin
						if (!ctrl_q[CTRL_AUTONEG_ENABLE_BIT] || link_negotiation_done ||
							(mode_q == MODE_FIBER)) begin
							spd_q   <= enter_spd;
							fdx_q   <= ctrl_q[CTRL_AUTONEG_ENABLE_BIT] ? link_negotiation_fdx : ctrl_q[CTRL_FDX];
							state_q <= (enter_spd == SPD_1000) ? ST_TRAIN : ST_LINK;
						end else if (pdet_valid && pdet_speed != SPD_1000) begin
							spd_q   <= enter_spd;
							fdx_q   <= 1'b0;
							state_q <= ST_LINK;
						end
					end
					ST_TRAIN: begin
						if (link_lost || fallback || train_fail) begin
							state_q <= ST_XOVER;
						end else if (train_ok) begin
							state_q <= ST_LINK;
						end
					end
					ST_LINK: begin
						if (link_lost) begin
							state_q <= ST_XOVER;
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// gigabit attempt counter and advertisement drop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q      <= 3'h0;
			gig_drop_q <= 1'b0;
		end else if (ce) begin
			if (restart_trig) begin
				cnt_q      <= 3'h0;
				gig_drop_q <= 1'b0;
			end else if (state_q == ST_TRAIN && train_ok && !link_lost && !fallback) begin
				cnt_q <= 3'h0;
			end else if (state_q == ST_TRAIN && fallback) begin
				gig_drop_q <= 1'b1;
				cnt_q      <= 3'h0;
			end else if (state_q == ST_LINK_NEGOTIATION && state_q != ST_TRAIN &&
				ctrl_q[CTRL_AUTONEG_ENABLE_BIT] && link_negotiation_done && link_negotiation_speed == SPD_1000 &&
				cnt_q != 3'h7) begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end

	// pair mapping search, stepping while no valid pulses arrive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			map_q   <= 2'h0;
			dwell_q <= 8'h00;
		end else if (ce) begin
			if (state_q == ST_XOVER && ctrl_q[CTRL_XOVER] && !pulse_ok) begin
				if (dwell_q == XOVER_DWELL_CYC - 8'h01) begin
					dwell_q <= 8'h00;
					map_q   <= map_q + 2'h1;
				end else begin
					dwell_q <= dwell_q + 8'h01;
				end
			end else if (state_q == ST_XOVER && !ctrl_q[CTRL_XOVER]) begin
				map_q   <= 2'h0;
				dwell_q <= 8'h00;
			end
		end
	end

	// polarity tracking, frozen once the link is up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pol_q <= 4'h0;
		end else if (ce && state_q != ST_LINK) begin
			if (!ctrl_q[CTRL_POL]) begin
				pol_q <= 4'h0;
			end else if (state_q == ST_TRAIN) begin
				pol_q <= train_pol_inv;
			end else begin
				pol_q <= pulse_pol_inv;
			end
		end
	end

	// mac-side negotiation kick on copper speed change
	assign link_enter = (state_q != ST_LINK) && (state_q != ST_IDLE) && !ctrl_q[CTRL_PD] &&
		!restart_trig && (((state_q == ST_TRAIN) && train_ok && !link_lost && !fallback &&
		!train_fail) || ((state_q == ST_LINK_NEGOTIATION) && enter_spd != SPD_1000 &&
		(!ctrl_q[CTRL_AUTONEG_ENABLE_BIT] || link_negotiation_done || (pdet_valid && pdet_speed != SPD_1000))));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sg_start_q <= 1'b0;
			sg_spd_q   <= SPD_1000;
		end else if (ce) begin
			sg_start_q <= 1'b0;
			if (link_enter && mode_q == MODE_SGMII && enter_spd != sg_spd_q) begin
				sg_start_q <= 1'b1;
				sg_spd_q   <= enter_spd;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign link_negotiation_start     = link_negotiation_start_q;
	assign adv_speeds     = mode_speeds(mode_q) & {~gig_drop_q, 2'h3};
	assign next_page_bit  = nptx_q;
	assign link_up        = (state_q == ST_LINK);
	assign link_speed     = spd_q;
	assign link_fdx       = fdx_q;
	assign pair_map       = (spd_q == SPD_1000) ? map_q : {1'b0, map_q[0] ^ map_q[1]};
	assign pol_inv        = pol_q;
	assign sgmii_an_start = sg_start_q;
	assign sgmii_speed    = sg_spd_q;
	assign serdes_sgmii   = (mode_q == MODE_SGMII);
	assign serdes_fiber   = (mode_q == MODE_FIBER);

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_in_link;
		state_q == ST_LINK [*2];
	endsequence
	sequence s_pdet_hit;
		state_q == ST_LINK_NEGOTIATION && ctrl_q[CTRL_AUTONEG_ENABLE_BIT] && !link_negotiation_done && pdet_valid &&
		mode_q != MODE_FIBER && !ctrl_q[CTRL_PD] && !restart_trig;
	endsequence

	a_pd_holds_idle: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		ctrl_q[CTRL_PD] |=> state_q == ST_IDLE) else $error("power-down not idle");
	a_pdet_half_dpx: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		s_pdet_hit ##0 pdet_speed != SPD_1000 |=> link_up && !link_fdx)
		else $error("parallel detect not half duplex");
	a_pdet_no_gig: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		s_pdet_hit ##0 pdet_speed == SPD_1000 |=> state_q == ST_LINK_NEGOTIATION)
		else $error("parallel detect took gigabit");
	a_train_clear_cnt: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		link_enter && state_q == ST_TRAIN |=> cnt_q == 3'h0 && link_up)
		else $error("attempt count not cleared");
	a_fallback_drop: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		state_q == ST_TRAIN && train_fail && cnt_q > ATTEMPT_MAX && ads_allowed &&
		!restart_trig && !ctrl_q[CTRL_PD] |=> !adv_speeds[2] ##1 state_q != ST_TRAIN)
		else $error("fallback missed");
	a_gig_only_adv: assert property (@(posedge aclk) disable iff (!aresetn)
		gig_only |-> adv_speeds == 3'h4 && !ads_allowed)
		else $error("gigabit-only advertisement wrong");
	a_pol_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
		s_in_link |-> $stable(pol_q)) else $error("polarity moved during link");
	a_sgmii_kick: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		link_enter && serdes_sgmii && enter_spd != sgmii_speed
		|=> sgmii_an_start && sgmii_speed == $past(enter_spd))
		else $error("mac-side negotiation not started");
	a_serdes_excl: assert property (@(posedge aclk) disable iff (!aresetn)
		!(serdes_sgmii && serdes_fiber)) else $error("serializer double use");
	a_xover_skip: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		state_q == ST_XOVER && !ctrl_q[CTRL_XOVER] && !ctrl_q[CTRL_PD] && !restart_trig
		|=> state_q == ST_LINK_NEGOTIATION && link_negotiation_start == ctrl_q[CTRL_AUTONEG_ENABLE_BIT])
		else $error("crossover stage not left");

endmodule : lsn_top

// *** tb/lsn_partner.sv ***
// remote link partner model: negotiation, parallel detection and training outcomes
`timescale 1ns/1ps
module lsn_partner
	import lsn_pkg::*;
(
	// clock and reset
	input  wire  logic       aclk,
	input  wire  logic       aresetn,
	// behaviour chosen by the bench
	input  wire  logic       nego,
	input  wire  logic [1:0] spd,
	input  wire  logic       fdx,
	input  wire  logic [1:0] wire_map,
	input  wire  logic [1:0] tres,
	input  wire  logic [7:0] delay,
	input  wire  logic [3:0] pol,
	input  wire  logic       drop,
	// what the partner sees of the device
	input  wire  logic       link_negotiation_start,
	input  wire  logic [1:0] pair_map,
	input  wire  logic [2:0] adv_speeds,
	// line status toward the device
	output logic             pulse_ok,
	output logic             pdet_valid,
	output logic [1:0]       pdet_speed,
	output logic             link_negotiation_done,
	output logic [1:0]       link_negotiation_speed,
	output logic             link_negotiation_fdx,
	output logic             train_ok,
	output logic             train_fail,
	output logic             cable_unfit,
	output logic             sig_poor,
	output logic             link_lost,
	output logic [3:0]       pulse_pol_inv,
	output logic [3:0]       train_pol_inv
);
	logic [7:0] cnt_q;
	logic [1:0] ph_q;
	logic [1:0] agreed;

	// pulses arrive only when the swap matches the cable, c/d ignored as at 10/100
	assign pulse_ok      = (pair_map[1] ^ pair_map[0]) == (wire_map[1] ^ wire_map[0]);
	assign link_lost     = drop;
	assign pulse_pol_inv = pol;
	assign train_pol_inv = pol;
	// partner speed, gigabit lowered to 100 when the device does not advertise it
	assign agreed        = (spd == SPD_1000 && !adv_speeds[2]) ? SPD_100 : spd;

	// answer after a chosen delay, then one training outcome at gigabit
	always_ff @(posedge aclk) begin
		link_negotiation_done <= 1'b0;
		pdet_valid <= 1'b0;
		{train_ok, train_fail, cable_unfit, sig_poor} <= 4'h0;
		{link_negotiation_speed, pdet_speed, link_negotiation_fdx} <= ~{link_negotiation_speed, pdet_speed, link_negotiation_fdx}; // values inverted every cycle
		if (!aresetn) begin
			ph_q <= 2'h0;
			cnt_q <= 8'h00;
			{link_negotiation_speed, pdet_speed, link_negotiation_fdx} <= 5'h00;
		end else if (link_negotiation_start) begin
			ph_q <= 2'h1;
			cnt_q <= delay;
		end else if (ph_q == 2'h1 && cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else if (ph_q == 2'h1) begin
			ph_q <= (nego && agreed == SPD_1000) ? 2'h2 : 2'h0;
			link_negotiation_done <= nego;
			pdet_valid <= !nego;
			{link_negotiation_speed, pdet_speed, link_negotiation_fdx} <= {agreed, agreed, fdx};
		end else if (ph_q == 2'h2) begin
			ph_q <= 2'h0;
			{train_ok, train_fail, cable_unfit, sig_poor} <= 4'h8 >> tres;
		end
	end
endmodule : lsn_partner

// *** tb/lsn_top_tb_top.sv ***
// bench for the link start-up block against the partner model
`timescale 1ns/1ps
module lsn_top_tb_top
	import lsn_pkg::*;
();
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, x, rdv;
	logic [3:0] s_axi_wstrb, pulse_pol_inv, train_pol_inv, pol_inv, p_pol, pv;
	logic [1:0] s_axi_bresp, s_axi_rresp, pdet_speed, link_negotiation_speed, link_speed, pair_map;
	logic [1:0] sgmii_speed, p_spd, p_map, p_tres, rr;
	logic pulse_ok, pdet_valid, link_negotiation_done, link_negotiation_fdx, train_ok, train_fail, cable_unfit, sig_poor;
	logic link_lost, link_negotiation_start, next_page_bit, link_up, link_fdx, sgmii_an_start;
	logic serdes_sgmii, serdes_fiber, p_nego, p_fdx, p_drop;
	logic [2:0] adv_speeds;
	logic [7:0] p_delay;
	int failures = 0;
	int n_tests = 0;
	int nfail = 0;
	int nsg = 0;
	int i;

	lsn_top u_lsn_top (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_ok, .pdet_valid, .pdet_speed,
		.link_negotiation_done, .link_negotiation_speed, .link_negotiation_fdx, .train_ok, .train_fail, .cable_unfit, .sig_poor,
		.link_lost, .pulse_pol_inv, .train_pol_inv, .link_negotiation_start, .adv_speeds, .next_page_bit,
		.link_up, .link_speed, .link_fdx, .pair_map, .pol_inv, .sgmii_an_start, .sgmii_speed,
		.serdes_sgmii, .serdes_fiber);

	lsn_partner u_lsn_partner (.aclk, .aresetn, .nego(p_nego), .spd(p_spd), .fdx(p_fdx),
		.wire_map(p_map), .tres(p_tres), .delay(p_delay), .pol(p_pol), .drop(p_drop),
		.link_negotiation_start, .pair_map, .adv_speeds, .pulse_ok, .pdet_valid, .pdet_speed, .link_negotiation_done,
		.link_negotiation_speed, .link_negotiation_fdx, .train_ok, .train_fail, .cable_unfit, .sig_poor, .link_lost,
		.pulse_pol_inv, .train_pol_inv);

	// clock of 5 ns
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// count training failures and mac-side restarts
	always @(posedge aclk) begin
		if (train_fail) nfail++;
		if (sgmii_an_start) nsg++;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	// advertisement expected for a mac mode
	function automatic logic [2:0] exp_adv(input logic [1:0] m);
		return (m == MODE_RTBI || m == MODE_FIBER) ? 3'h4 : 3'h7;
	endfunction : exp_adv

	// pair mapping as seen at 10/100
	function automatic logic [1:0] fold(input logic [1:0] m);
		return {1'b0, m[1] ^ m[0]};
	endfunction : fold

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tdone(input string s);
		$display("%s done, %0d checks, %0d mismatches", s, n_tests, failures);
	endtask : tdone

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		chk(r, er);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic wait_link();
		int t;
		t = 0;
		while (link_up !== 1'b1 && t < 3000) begin
			@(posedge aclk);
			t++;
		end
		chk(link_up, 1'b1);
	endtask : wait_link

	task automatic restart();
		wr(ADDR_CTRL, CTRL_RST | 32'h0000_0004, RESP_OKAY);
		wait_link();
	endtask : restart

	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// watchdog
	initial begin
		repeat (80000) @(posedge aclk);
		failures++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, ce, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {2'h1, 48'h0, 4'hF};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{p_nego, p_fdx, p_drop, p_spd, p_map, p_tres, p_pol} = {3'h6, SPD_100, 8'h00};
		p_delay = 8'h10;
		x = 32'h0000_BA62; // seed
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// register defaults, next-page bit, unmapped and read-only places
		rd(ADDR_CTRL, rdv, rr);
		chk(rdv, CTRL_RST);
		wr(ADDR_NPTX, 32'h0000_0001, RESP_OKAY);
		chk(next_page_bit, 1'b1);
		rd(8'h14, rdv, rr);
		chk(rdv, 32'h0);
		chk(rr, RESP_SLVERR);
		wr(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
		wr(ADDR_STAT, 32'hFFFF_FFFF, RESP_OKAY);
		rd(ADDR_ADV, rdv, rr);
		chk(rdv[2:0], 3'h7);
		tdone("registers");
		// random partners: negotiating or parallel detected
		for (i = 0; i < 6; i++) begin
			x = xs(x);
			{p_nego, p_fdx, p_map, p_pol, p_delay} <= {x[0], x[1], x[3:2], x[7:4], 1'b0, x[14:8]};
			p_spd <= x[15] ? SPD_100 : SPD_10;
			@(posedge aclk);
			restart();
			chk(link_speed, p_spd);
			chk(link_fdx, p_nego & p_fdx);
			chk(pair_map, fold(p_map));
			chk(pol_inv, p_pol);
		end
		pv = p_pol;
		p_pol <= ~p_pol;
		repeat (20) @(posedge aclk);
		chk(pol_inv, pv);
		tdone("random links");
		// gigabit partner without negotiation is never linked
		{p_nego, p_spd, p_delay} <= {1'b0, SPD_1000, 8'h10};
		wr(ADDR_CTRL, (CTRL_RST & ~32'h0000_0010) | 32'h0000_0004, RESP_OKAY);
		repeat (400) @(posedge aclk);
		chk(link_up, 1'b0);
		chk(pair_map, 2'h0);
		// power down, link loss, soft reset
		{p_nego, p_spd} <= {1'b1, SPD_100};
		wr(ADDR_CTRL, CTRL_RST | 32'h0000_0002, RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk(link_up, 1'b0);
		wr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
		wait_link();
		p_drop <= 1'b1;
		repeat (3) @(posedge aclk);
		p_drop <= 1'b0;
		chk(link_up, 1'b0);
		wait_link();
		wr(ADDR_CTRL, CTRL_RST | 32'h0000_0008, RESP_OKAY);
		wait_link();
		// negotiation off: forced 100 half, crossover still found
		p_map <= 2'h2;
		wr(ADDR_CTRL, (CTRL_RST & ~32'h0000_0001) | 32'h0000_0004, RESP_OKAY);
		wait_link();
		chk({link_speed, link_fdx, pair_map}, {SPD_100, 1'b0, 2'h1});
		tdone("start-up triggers");
		// gigabit link, polarity from training, attempts cleared
		{p_spd, p_tres, p_pol} <= {SPD_1000, 2'h0, 4'hA};
		restart();
		chk({link_speed, pol_inv}, {SPD_1000, 4'hA});
		rd(ADDR_STAT, rdv, rr);
		chk(rdv[9:7], 3'h0);
		// four failed gigabit attempts, then fallback to 100
		p_tres <= 2'h1;
		nfail = 0;
		restart();
		chk({nfail[3:0], adv_speeds, link_speed}, {4'h4, 3'h3, SPD_100});
		rd(ADDR_STAT, rdv, rr);
		chk(rdv[STAT_DROP], 1'b1);
		// unfit cable and poor signal drop gigabit at once
		for (i = 2; i < 4; i++) begin
			p_tres <= i[1:0];
			nfail = 0;
			restart();
			chk({nfail[3:0], adv_speeds, link_speed}, {4'h0, 3'h3, SPD_100});
		end
		tdone("downspeed");
		// mac modes: serializer use and advertisement
		wr(ADDR_CTRL, CTRL_RST | 32'h0000_0004, RESP_OKAY);
		for (i = 0; i < 4; i++) begin
			wr(ADDR_MODE, i, RESP_OKAY);
			chk({serdes_sgmii, serdes_fiber, adv_speeds}, {i == 1, i == 3, exp_adv(i[1:0])});
		end
		// gigabit-only mode keeps gigabit on an unfit cable
		wr(ADDR_MODE, MODE_RTBI, RESP_OKAY);
		p_tres <= 2'h2;
		wr(ADDR_CTRL, CTRL_RST | 32'h0000_0004, RESP_OKAY);
		repeat (300) @(posedge aclk);
		rd(ADDR_STAT, rdv, rr);
		chk({rdv[STAT_DROP], adv_speeds}, {1'b0, 3'h4});
		tdone("mac modes");
		// serial mac side renegotiates only on a speed change
		wr(ADDR_MODE, MODE_SGMII, RESP_OKAY);
		{p_spd, p_tres} <= {SPD_100, 2'h0};
		nsg = 0;
		for (i = 0; i < 3; i++) begin
			if (i == 2) p_spd <= SPD_10;
			restart();
			repeat (4) @(posedge aclk);
			chk({nsg[1:0], sgmii_speed}, (i == 2) ? {2'h2, SPD_10} : {2'h1, SPD_100});
		end
		tdone("serial mac");
		test_done();
	end
endmodule : lsn_top_tb_top
